// File: verilog/sirq_consts.svh
// sirq_consts.svh: timing counts, frame layout and reset values of the serial irq/rx-error block
// assumes: included by its bare name from the package or a design file
`ifndef SIRQ_CONSTS_SVH
`define SIRQ_CONSTS_SVH

// ----------------------------------------
// oversampling and frame layout
// ----------------------------------------
`define SIRQ_OVS_RATIO     16
`define SIRQ_OVS_HALF      8
`define SIRQ_DATA_BITS     8
`define SIRQ_CNT_W         4
`define SIRQ_BIT_W         4
`define SIRQ_DIV_W         16
`define SIRQ_DIV_RESET     16'h000F

// ----------------------------------------
// reset values
// ----------------------------------------
`define SIRQ_TDR_RESET     8'h00
`define SIRQ_RDR_RESET     8'h00
`define SIRQ_EMPTY_RESET   1'b1

// ----------------------------------------
// request priority codes
// ----------------------------------------
`define SIRQ_PRI_NONE      2'h0
`define SIRQ_PRI_TX        2'h1
`define SIRQ_PRI_RX        2'h2
`define SIRQ_PRI_ERR       2'h3

`endif

// File: verilog/sirq_pkg.sv
// sirq_pkg.sv: types of the serial irq/rx-error block
// assumes: sirq_consts.svh is on the include path
package sirq_pkg;
    `include "sirq_consts.svh"

    // receiver state, gray along the usual path
    typedef enum logic [1:0] {
        SIRQ_IDLE  = 2'b00,
        SIRQ_START = 2'b01,
        SIRQ_DATA  = 2'b11,
        SIRQ_STOP  = 2'b10
    } sirq_rx_state_e;

    typedef logic [7:0] sirq_byte_t;
endpackage

// File: verilog/sirq_serial_unit.sv
// sirq_serial_unit.sv: serial unit receive path, status flags and three interrupt requests
// assumes: one clock mclk, active-low async nrst, async serial input rxd, 8N1 or 8E1/8O1 frames
`timescale 1ns/1ps
`default_nettype none
`include "sirq_consts.svh"

// Functional notes
// R1: three separate request outputs: transmit-end, receive-end, receive-error
// R2: transmit-end follows empty flag, receive-end follows full flag, each enable-gated
// R3: receive-error is OR of overrun, framing, parity flags, gated by rx enable; code gates it by rx_irq_enable, not rx_enable
// R4: priority: receive-error highest, then receive-end, then transmit-end
// R5: only transmit-end and receive-end may go to the transfer controller
// R6: controller write to transmit data clears empty flag when triggered by transmit-end
// R7: controller read of receive data clears full flag when triggered by receive-end
// R8: transmit data writable anytime; writing while not empty overwrites pending byte
// R9: software should check empty flag is 1 before writing transmit data
// R10: overrun sets overrun flag, full stays set, no copy into receive data
// R11: framing/parity without overrun set flags and copy data; full flag stays 0
// R12: continuous low line gives framing error and all-zero byte in receive data
// R13: reception continues during break so framing error recurs after clearing
// R14: receive sample clock runs at sixteen times the bit rate
// R15: start edge found by sampling line on sample clock falling edges
// R16: every frame bit sampled on rising sample edge at bit centre
// R17: overrun raised when next frame completes while full flag still set
// R18: after overrun, reception blocked until overrun flag cleared
// R19: software clears full flag by reading status then writing zero
// R20: centre sample eight sample clocks after boundary, then every sixteen
module sirq_serial_unit
    import sirq_pkg::*;
#(
    parameter int DIV_W = `SIRQ_DIV_W
) (
    input  wire logic             mclk,            // 250 MHz system clock
    input  wire logic             nrst,            // async reset, active low
    input  wire logic             rxd,             // serial receive line, async
    input  wire logic [DIV_W-1:0] baud_div,        // half-period of 16x clock minus one
    input  wire logic             rx_enable,       // receiver on
    input  wire logic             parity_enable,   // frame carries parity bit
    input  wire logic             parity_odd,      // odd parity when set
    input  wire logic             tx_irq_enable,   // transmit-end request enable
    input  wire logic             rx_irq_enable,   // receive-end/error request enable
    input  wire logic             tx_dtc_route,    // tx-end serviced by transfer controller
    input  wire logic             rx_dtc_route,    // rx-end serviced by transfer controller
    input  wire logic             status_read,     // software read of status, pulse
    input  wire logic             clr_full,        // software writes 0 to full flag, pulse
    input  wire logic             clr_empty,       // software writes 0 to empty flag, pulse
    input  wire logic             clr_overrun,     // software writes 0 to overrun flag, pulse
    input  wire logic             clr_framing,     // software writes 0 to framing flag, pulse
    input  wire logic             clr_parity,      // software writes 0 to parity flag, pulse
    input  wire logic             tdr_write,       // write of transmit data, pulse
    input  wire logic             tdr_by_dtc,      // that write is a controller access
    input  wire logic [7:0]       tdr_wdata,       // transmit data written
    input  wire logic             rdr_read,        // read of receive data, pulse
    input  wire logic             rdr_by_dtc,      // that read is a controller access
    input  wire logic             tsr_load,        // transmitter moved data to shift reg, pulse
    output logic [7:0]            tx_data_reg,     // transmit data register
    output logic [7:0]            rx_data_reg,     // receive data register
    output logic                  tx_buf_empty_flag, // transmit buffer empty
    output logic                  rx_buf_full_flag,  // receive buffer full
    output logic                  overrun_flag,    // overrun error
    output logic                  framing_err_flag, // framing error
    output logic                  parity_err_flag, // parity error
    output logic                  tx_end_irq,      // to cpu interrupt controller
    output logic                  rx_end_irq,      // to cpu interrupt controller
    output logic                  rx_error_irq,    // to cpu interrupt controller, always
    output logic                  tx_end_dtc_req,  // to transfer controller
    output logic                  rx_end_dtc_req,  // to transfer controller
    output logic [1:0]            irq_priority     // highest pending request code
);

    // ----------------------------------------
    // input synchroniser
    // ----------------------------------------
    logic rxd_meta_r, rxd_sync_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rxd_meta_r <= 1'b1;
            rxd_sync_r <= 1'b1;
        end else begin
            rxd_meta_r <= rxd;
            rxd_sync_r <= rxd_meta_r;
        end
    end

    // ----------------------------------------
    // 16x sample clock as rise/fall enables
    // ----------------------------------------
    logic [DIV_W-1:0] div_r, div_nxt;
    logic             ovs_r, ovs_nxt;
    logic             ovs_rise, ovs_fall;

    // R14: sixteen-times clock
    always_comb begin
        div_nxt  = div_r - 1'b1;
        ovs_nxt  = ovs_r;
        ovs_rise = 1'b0;
        ovs_fall = 1'b0;
        if (div_r == '0) begin
            div_nxt  = baud_div;
            ovs_nxt  = ~ovs_r;
            ovs_rise = ~ovs_r;
            ovs_fall = ovs_r;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_r <= DIV_W'(`SIRQ_DIV_RESET);
            ovs_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            ovs_r <= ovs_nxt;
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    sirq_rx_state_e             st_r, st_nxt;
    logic [`SIRQ_CNT_W-1:0]     tick_r, tick_nxt;
    logic [`SIRQ_BIT_W-1:0]     bit_r, bit_nxt;
    sirq_byte_t                 rsr_r, rsr_nxt;
    logic                       par_r, par_nxt;
    logic                       perr_r, perr_nxt;
    logic                       frame_done, stop_bit;
    logic                       centre;

    assign centre = ovs_rise && (tick_r == '0);

    always_comb begin
        st_nxt     = st_r;
        tick_nxt   = tick_r;
        bit_nxt    = bit_r;
        rsr_nxt    = rsr_r;
        par_nxt    = par_r;
        perr_nxt   = perr_r;
        frame_done = 1'b0;
        stop_bit   = 1'b1;
        if (ovs_rise && tick_r != '0 && st_r != SIRQ_IDLE) begin
            tick_nxt = tick_r - 1'b1;
        end
        unique case (st_r)
            SIRQ_IDLE: begin
                // R15: start edge on falling sample edge
                // R18: blocked while overrun pending
                if (ovs_fall && !rxd_sync_r && rx_enable && !overrun_flag) begin
                    // R20: half a bit to the centre
                    tick_nxt = `SIRQ_CNT_W'(`SIRQ_OVS_HALF - 1);
                    st_nxt   = SIRQ_START;
                end
            end
            SIRQ_START: begin
                // R16: start bit at its centre
                if (centre) begin
                    tick_nxt = `SIRQ_CNT_W'(`SIRQ_OVS_RATIO - 1);
                    bit_nxt  = '0;
                    par_nxt  = parity_odd;
                    perr_nxt = 1'b0;
                    st_nxt   = rxd_sync_r ? SIRQ_IDLE : SIRQ_DATA;
                end
            end
            SIRQ_DATA: begin
                // R20: every sixteen clocks
                if (centre) begin
                    tick_nxt = `SIRQ_CNT_W'(`SIRQ_OVS_RATIO - 1);
                    bit_nxt  = bit_r + 1'b1;
                    if (bit_r < `SIRQ_BIT_W'(`SIRQ_DATA_BITS)) begin
                        rsr_nxt = {rxd_sync_r, rsr_r[7:1]};
                        par_nxt = par_r ^ rxd_sync_r;
                    end else begin
                        perr_nxt = par_r ^ rxd_sync_r;
                    end
                    if (bit_r == `SIRQ_BIT_W'(`SIRQ_DATA_BITS - 1) + {3'h0, parity_enable}) begin
                        st_nxt = SIRQ_STOP;
                    end
                end
            end
            SIRQ_STOP: begin
                if (centre) begin
                    frame_done = 1'b1;
                    stop_bit   = rxd_sync_r;
                    st_nxt     = SIRQ_IDLE;
                end
            end
        endcase
        if (!rx_enable) begin
            st_nxt = SIRQ_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r   <= SIRQ_IDLE;
            tick_r <= '0;
            bit_r  <= '0;
            rsr_r  <= `SIRQ_RDR_RESET;
            par_r  <= 1'b0;
            perr_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            tick_r <= tick_nxt;
            bit_r  <= bit_nxt;
            rsr_r  <= rsr_nxt;
            par_r  <= par_nxt;
            perr_r <= perr_nxt;
        end
    end

    // ----------------------------------------
    // flags and data registers
    // ----------------------------------------
    sirq_byte_t tdr_r, tdr_nxt, rdr_r, rdr_nxt;
    logic       empty_r, empty_nxt, full_r, full_nxt;
    logic       ovr_r, ovr_nxt, fer_r, fer_nxt, per_r, per_nxt;
    logic       full_seen_r, full_seen_nxt;
    logic       ovr_ev, fer_ev, per_ev;

    always_comb begin
        tdr_nxt       = tdr_r;
        rdr_nxt       = rdr_r;
        empty_nxt     = empty_r;
        full_nxt      = full_r;
        ovr_nxt       = ovr_r;
        fer_nxt       = fer_r;
        per_nxt       = per_r;
        full_seen_nxt = full_seen_r;
        // R17: next frame ends while still full
        ovr_ev = frame_done && full_r;
        // R12: zero stop bit on a held-low line
        // R13: break keeps producing framing errors
        fer_ev = frame_done && !stop_bit;
        per_ev = frame_done && parity_enable && perr_r;

        // R8: write replaces pending byte
        if (tdr_write) begin
            tdr_nxt = tdr_wdata;
        end
        // R19: status read arms software clear
        if (status_read) begin
            full_seen_nxt = full_r;
        end
        if (clr_empty) begin
            empty_nxt = 1'b0;
        end
        // R6: controller write clears empty flag
        if (tdr_write && tdr_by_dtc && tx_end_dtc_req) begin
            empty_nxt = 1'b0;
        end
        if (tsr_load) begin
            empty_nxt = 1'b1;
        end
        if (clr_full && full_seen_r) begin
            full_nxt      = 1'b0;
            full_seen_nxt = 1'b0;
        end
        // R7: controller read clears full flag
        if (rdr_read && rdr_by_dtc && rx_end_dtc_req) begin
            full_nxt = 1'b0;
        end
        if (clr_overrun) begin
            ovr_nxt = 1'b0;
        end
        if (clr_framing) begin
            fer_nxt = 1'b0;
        end
        if (clr_parity) begin
            per_nxt = 1'b0;
        end
        if (frame_done) begin
            fer_nxt = fer_nxt | fer_ev;
            per_nxt = per_nxt | per_ev;
            if (ovr_ev) begin
                // R10: overrun keeps full set, no copy
                ovr_nxt  = 1'b1;
                full_nxt = 1'b1;
            end else begin
                // R11: copy; full only on clean frame
                // R12: break byte is all zero
                rdr_nxt = rsr_r;
                if (!fer_ev && !per_ev) begin
                    full_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tdr_r       <= `SIRQ_TDR_RESET;
            rdr_r       <= `SIRQ_RDR_RESET;
            empty_r     <= `SIRQ_EMPTY_RESET;
            full_r      <= 1'b0;
            ovr_r       <= 1'b0;
            fer_r       <= 1'b0;
            per_r       <= 1'b0;
            full_seen_r <= 1'b0;
        end else begin
            tdr_r       <= tdr_nxt;
            rdr_r       <= rdr_nxt;
            empty_r     <= empty_nxt;
            full_r      <= full_nxt;
            ovr_r       <= ovr_nxt;
            fer_r       <= fer_nxt;
            per_r       <= per_nxt;
            full_seen_r <= full_seen_nxt;
        end
    end

    assign tx_data_reg       = tdr_r;
    assign rx_data_reg       = rdr_r;
    assign tx_buf_empty_flag = empty_r;
    assign rx_buf_full_flag  = full_r;
    assign overrun_flag      = ovr_r;
    assign framing_err_flag  = fer_r;
    assign parity_err_flag   = per_r;

    // ----------------------------------------
    // requests and priority
    // ----------------------------------------
    logic tx_req, rx_req, err_req;

    // R2: enable-gated buffer flags
    assign tx_req  = empty_r & tx_irq_enable;
    assign rx_req  = full_r & rx_irq_enable;
    // R3: error OR gated by rx irq enable
    assign err_req = (ovr_r | fer_r | per_r) & rx_irq_enable;

    // R1: separate lines
    // R5: error never routed to controller
    assign tx_end_irq     = tx_req & ~tx_dtc_route;
    assign rx_end_irq     = rx_req & ~rx_dtc_route;
    assign rx_error_irq   = err_req;
    assign tx_end_dtc_req = tx_req & tx_dtc_route;
    assign rx_end_dtc_req = rx_req & rx_dtc_route;

    // R4: error over rx-end over tx-end
    always_comb begin
        if (err_req) begin
            irq_priority = `SIRQ_PRI_ERR;
        end else if (rx_req) begin
            irq_priority = `SIRQ_PRI_RX;
        end else if (tx_req) begin
            irq_priority = `SIRQ_PRI_TX;
        end else begin
            irq_priority = `SIRQ_PRI_NONE;
        end
    end

endmodule
`default_nettype wire

// File: tb/sirq_serial_unit_sva.sv
// sirq_serial_unit_sva.sv: port checker for the serial irq/rx-error block
// assumes: bound to sirq_serial_unit, one clock mclk, nrst active low
`timescale 1ns/1ps
`default_nettype none
module sirq_serial_unit_chk (
    input wire logic       mclk, nrst, tx_irq_enable, rx_irq_enable, // clock, reset, enables
    input wire logic       tx_dtc_route, rx_dtc_route, tsr_load,     // routes, shift load
    input wire logic       tdr_write, tdr_by_dtc, rdr_read, rdr_by_dtc, // data accesses
    input wire logic [7:0] tdr_wdata, tx_data_reg, rx_data_reg,   // data
    input wire logic       tx_buf_empty_flag, rx_buf_full_flag, overrun_flag, // flags
    input wire logic       framing_err_flag, parity_err_flag,     // error flags
    input wire logic       tx_end_irq, rx_end_irq, rx_error_irq,  // cpu requests
    input wire logic       tx_end_dtc_req, rx_end_dtc_req,        // controller requests
    input wire logic [1:0] irq_priority                           // ranked request code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic err_any;
    assign err_any = overrun_flag | framing_err_flag | parity_err_flag;
    sequence s_dtc_wr;
        tdr_write && tdr_by_dtc && tx_end_dtc_req && !tsr_load;
    endsequence
    sequence s_dtc_rd;
        rdr_read && rdr_by_dtc && rx_end_dtc_req;
    endsequence
    a_tx_req_gate: assert property (
        tx_end_irq == (tx_buf_empty_flag && tx_irq_enable && !tx_dtc_route) &&
        tx_end_dtc_req == (tx_buf_empty_flag && tx_irq_enable && tx_dtc_route))
        else $error("transmit-end request gating wrong");
    a_rx_req_gate: assert property (
        rx_end_irq == (rx_buf_full_flag && rx_irq_enable && !rx_dtc_route) &&
        rx_end_dtc_req == (rx_buf_full_flag && rx_irq_enable && rx_dtc_route))
        else $error("receive-end request gating wrong");
    a_err_cpu_only: assert property (rx_error_irq == (err_any && rx_irq_enable))
        else $error("receive-error request wrong");
    a_prio_rank: assert property (irq_priority == ((err_any && rx_irq_enable) ? 2'h3 :
        (rx_buf_full_flag && rx_irq_enable) ? 2'h2 : (tx_buf_empty_flag && tx_irq_enable)
        ? 2'h1 : 2'h0))
        else $error("request priority code wrong");
    a_dtc_wr_clr: assert property (s_dtc_wr |=> !tx_buf_empty_flag)
        else $error("controller write left empty flag set");
    a_dtc_rd_clr: assert property (s_dtc_rd |=> !rx_buf_full_flag)
        else $error("controller read left full flag set");
    a_tdr_capture: assert property (tdr_write |=> tx_data_reg == $past(tdr_wdata))
        else $error("transmit data not taken");
    a_overrun_keep: assert property (
        $rose(overrun_flag) |-> rx_buf_full_flag && $stable(rx_data_reg))
        else $error("overrun changed receive data or full flag");
    a_err_no_full: assert property (
        $rose(framing_err_flag) && !$past(rx_buf_full_flag) |-> !rx_buf_full_flag)
        else $error("framing error frame set full flag");
    a_ovr_blocks: assert property (overrun_flag |=> $stable(rx_data_reg))
        else $error("reception not blocked after overrun");
endmodule
`default_nettype wire

// File: tb/sirq_line_model.sv
// sirq_line_model.sv: remote asynchronous transmitter driving the receive line
// assumes: bit time of BIT_CYC mclk cycles, frames started by bench tasks
`timescale 1ns/1ps
`default_nettype none
module sirq_line_model #(
    parameter int BIT_CYC = 64
) (
    input  wire logic mclk, // system clock
    output var logic  rxd   // serial line, idle high
);
    initial rxd = 1'b1;
    task automatic hold(input logic v, input int n);
        rxd <= v;
        repeat (n) @(posedge mclk);
    endtask
    // lsb first, optional parity, one stop; faults only when asked
    task automatic send(input logic [7:0] d, input logic pen, podd, bad_par, bad_stop);
        hold(1'b0, BIT_CYC);
        for (int i = 0; i < 8; i++) hold(d[i], BIT_CYC);
        if (pen) hold(^d ^ podd ^ bad_par, BIT_CYC);
        // a low stop rises before the next possible start centre
        if (bad_stop) hold(1'b0, BIT_CYC * 3 / 4);
        hold(1'b1, bad_stop ? BIT_CYC / 4 : BIT_CYC);
    endtask
    task automatic brk(input int bits);
        hold(1'b0, bits * BIT_CYC);
        hold(1'b1, BIT_CYC);
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// tb_top.sv: self-checking bench of the serial irq/rx-error block
// assumes: package, line model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sirq_consts.svh"
module tb_top;
    localparam int BIT_CYC = 16 * 2 * (1 + 1);
    logic       mclk, nrst, rxd, tdr_by_dtc, rdr_by_dtc;
    logic [5:0] cf;
    logic [8:0] pul;
    logic [7:0] tdr_wdata, tx_data_reg, rx_data_reg;
    logic [1:0] irq_priority;
    logic       tx_buf_empty_flag, rx_buf_full_flag, overrun_flag, framing_err_flag;
    logic       parity_err_flag, tx_end_irq, rx_end_irq, rx_error_irq, tx_end_dtc_req;
    logic       rx_end_dtc_req;
    int         bad_count, n_tests, cyc;
    sirq_serial_unit u_sirq_serial_unit (
        .mclk, .nrst, .rxd, .baud_div(16'h0001), .rx_enable(1'b1), .parity_enable(cf[1]),
        .parity_odd(cf[0]), .tx_irq_enable(cf[5]), .rx_irq_enable(cf[4]),
        .tx_dtc_route(cf[3]), .rx_dtc_route(cf[2]), .status_read(pul[0]),
        .clr_full(pul[1]), .clr_empty(pul[2]), .clr_overrun(pul[3]), .clr_framing(pul[4]),
        .clr_parity(pul[5]), .tdr_write(pul[6]), .tdr_by_dtc, .tdr_wdata,
        .rdr_read(pul[7]), .rdr_by_dtc, .tsr_load(pul[8]), .tx_data_reg, .rx_data_reg,
        .tx_buf_empty_flag, .rx_buf_full_flag, .overrun_flag, .framing_err_flag,
        .parity_err_flag, .tx_end_irq, .rx_end_irq, .rx_error_irq, .tx_end_dtc_req,
        .rx_end_dtc_req, .irq_priority
    );
    sirq_line_model #(.BIT_CYC(BIT_CYC)) u_sirq_line_model (.mclk, .rxd);
    always #2 mclk = ~mclk;
    task automatic chk(input string what, input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic strobe(input logic [8:0] m);
        @(posedge mclk) pul <= m;
        @(posedge mclk) pul <= '0;
        #1;
    endtask
    task automatic cfg(input logic [5:0] v);
        @(posedge mclk) cf <= v;
        @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] d, input logic b);
        tdr_wdata <= d;
        tdr_by_dtc <= b;
        strobe(9'h040);
    endtask
    task automatic t_reset;
        @(posedge mclk);
        #1;
        chk("tdr", tx_data_reg, `SIRQ_TDR_RESET);
        chk("rdr", rx_data_reg, `SIRQ_RDR_RESET);
        chk("flags", {tx_buf_empty_flag, rx_buf_full_flag, overrun_flag,
            framing_err_flag, parity_err_flag}, 8'h10);
    endtask
    task automatic t_tx_route;
        for (int i = 0; i < 4; i++) begin
            cfg({i[1], 1'b0, i[0], 3'b000});
            chk("tx irq", tx_end_irq, i[1] & !i[0]);
            chk("tx dtc", tx_end_dtc_req, i[1] & i[0]);
            chk("prio", irq_priority, i[1] ? `SIRQ_PRI_TX : `SIRQ_PRI_NONE);
        end
    endtask
    task automatic t_dtc_tx;
        chk("empty", tx_buf_empty_flag, 1'b1);
        wr(8'hA5, 1'b1);
        chk("empty", tx_buf_empty_flag, 1'b0);
        wr(8'h5A, 1'b0);
        chk("tdr", tx_data_reg, 8'h5A);
        strobe(9'h100);
        cfg(6'h00);
        wr(8'hC3, 1'b1);
        chk("empty", tx_buf_empty_flag, 1'b1);
        chk("tdr", tx_data_reg, 8'hC3);
        strobe(9'h004);
    endtask
    task automatic t_rx_clean;
        cfg(6'h10);
        u_sirq_line_model.send(8'h96, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("rdr", rx_data_reg, 8'h96);
        chk("rx irq", rx_end_irq, 1'b1);
        chk("prio", irq_priority, `SIRQ_PRI_RX);
        strobe(9'h002);
        chk("full", rx_buf_full_flag, 1'b1);
        strobe(9'h001);
        strobe(9'h002);
        chk("full", rx_buf_full_flag, 1'b0);
    endtask
    task automatic t_overrun;
        cfg(6'h14);
        u_sirq_line_model.send(8'h11, 1'b0, 1'b0, 1'b0, 1'b0);
        u_sirq_line_model.send(8'h22, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("ovr full", {overrun_flag, rx_buf_full_flag}, 8'h03);
        chk("rdr", rx_data_reg, 8'h11);
        chk("err irq", {rx_error_irq, rx_end_irq}, 8'h02);
        chk("prio", irq_priority, `SIRQ_PRI_ERR);
        u_sirq_line_model.send(8'h33, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("rdr", rx_data_reg, 8'h11);
        strobe(9'h008);
        u_sirq_line_model.send(8'h44, 1'b0, 1'b0, 1'b1, 1'b0);
        chk("rdr", rx_data_reg, 8'h11);
        chk("ovr", overrun_flag, 1'b1);
        strobe(9'h008);
        rdr_by_dtc <= 1'b1;
        strobe(9'h080);
        chk("full", rx_buf_full_flag, 1'b0);
        u_sirq_line_model.send(8'h44, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("rdr", rx_data_reg, 8'h44);
        chk("rx dtc", rx_end_dtc_req, 1'b1);
        strobe(9'h080);
        chk("full", rx_buf_full_flag, 1'b0);
        rdr_by_dtc <= 1'b0;
    endtask
    task automatic t_errors;
        cfg(6'h12);
        u_sirq_line_model.send(8'h5B, 1'b1, 1'b0, 1'b1, 1'b0);
        chk("per full", {parity_err_flag, rx_buf_full_flag}, 8'h02);
        chk("rdr", rx_data_reg, 8'h5B);
        chk("err irq", rx_error_irq, 1'b1);
        strobe(9'h020);
        cfg(6'h13);
        u_sirq_line_model.send(8'h6C, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("per full", {parity_err_flag, rx_buf_full_flag}, 8'h01);
        strobe(9'h001);
        strobe(9'h002);
        u_sirq_line_model.send(8'hE7, 1'b1, 1'b1, 1'b1, 1'b1);
        chk("errs", {framing_err_flag, parity_err_flag, rx_buf_full_flag}, 8'h06);
        chk("rdr", rx_data_reg, 8'hE7);
        strobe(9'h030);
        chk("err irq", rx_error_irq, 1'b0);
        cfg(6'h10);
    endtask
    task automatic t_break;
        int n;
        fork
            u_sirq_line_model.brk(30);
            begin
                for (n = 0; n < 1000 && framing_err_flag !== 1'b1; n++) @(posedge mclk);
                chk("fer", framing_err_flag, 1'b1);
                chk("rdr", rx_data_reg, 8'h00);
                strobe(9'h010);
                for (n = 0; n < 1000 && framing_err_flag !== 1'b1; n++) @(posedge mclk);
                chk("fer again", framing_err_flag, 1'b1);
            end
        join
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            stop_test;
        end
    end
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        cf = '0;
        pul = '0;
        tdr_wdata = '0;
        tdr_by_dtc = 1'b0;
        rdr_by_dtc = 1'b0;
        bad_count = 0;
        n_tests = 0;
        cyc = 0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        t_reset;
        t_tx_route;
        t_dtc_tx;
        t_rx_clean;
        t_overrun;
        t_errors;
        t_break;
        stop_test;
    end
endmodule
bind sirq_serial_unit sirq_serial_unit_chk u_chk (
    .mclk, .nrst, .tx_irq_enable, .rx_irq_enable, .tx_dtc_route, .rx_dtc_route,
    .tsr_load, .tdr_write, .tdr_by_dtc, .rdr_read, .rdr_by_dtc, .tdr_wdata, .tx_data_reg,
    .rx_data_reg, .tx_buf_empty_flag, .rx_buf_full_flag, .overrun_flag,
    .framing_err_flag, .parity_err_flag, .tx_end_irq, .rx_end_irq, .rx_error_irq,
    .tx_end_dtc_req, .rx_end_dtc_req, .irq_priority
);
`default_nettype wire
